// file: low_power_defines.vh
`ifndef LOW_POWER_DEFINES_VH
`define LOW_POWER_DEFINES_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define OFF_MODE_CTRL 6'h00
`define OFF_WAKE_PIN_EN 6'h04
`define OFF_VMON_CTRL 6'h08
`define OFF_BAT_CTRL 6'h0c
`define OFF_VOS_CTRL 6'h10
`define OFF_PULL_UP 6'h14
`define OFF_PULL_DN 6'h18
`define OFF_WAKE_SRC_EN 6'h1c
`define OFF_STATUS 6'h20
`define OFF_WAKE_FLAGS 6'h24

// ************************************************************
// mode control fields
// ************************************************************
`define MC_MODE_LSB 0
`define MC_MODE_MSB 2
`define MC_ENTER_BIT 4
`define MC_RET_LSB 5
`define MC_RET_MSB 6
`define MC_FLASH_PD_BIT 7
`define MC_IO_RELEASE_BIT 8
`define MC_W 9
`define MC_RESET 9'h000
`define MC_WR_MASK 9'h1ef

// ************************************************************
// power states and requested modes
// ************************************************************
`define ST_STOP0 3'h0
`define ST_STOP1 3'h1
`define ST_STOP2 3'h2
`define ST_STOP3 3'h3
`define ST_STANDBY 3'h4
`define ST_SHUTDOWN 3'h5
`define ST_RUN 3'h6
`define ST_BATTERY 3'h7

// second bank retention choices and segment enables
`define RET_8K 2'h0
`define RET_56K 2'h1
`define SEG_8K 3'h1
`define SEG_56K 3'h3
`define SEG_FULL 3'h7

// ************************************************************
// wake sources, widths, reset values
// ************************************************************
`define SRC_PIN 0
`define SRC_WDG_RST 1
`define SRC_WDG_INT 2
`define SRC_GDMA 3
`define SRC_LPDMA 4
`define SRC_MDF 5
`define SRC_ADF 6
`define SRC_SERIAL 7
`define SRC_W 8
`define PIN_W 24
`define TAMPER_W 8
`define OSC_REQ_W 8
`define VMON_W 8
`define BAT_W 9
`define BAT_CHARGE_BIT 8
`define VOS_W 2
`define BANK_W 4
`define SYNC_W 58
`define SYNC_RESET 58'h000_0000_8000_0000
`define ZERO32 32'h00000000

`endif

// file: low_power_mode_wake_control.v
`timescale 1ns/1ps
`default_nettype none
`include "low_power_defines.vh"

module low_power_mode_wake_control (
  input wire clk,
  input wire srst,
  input wire clk_en,
  // avalon-mm slave
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire avs_secure,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // same-clock security attributes
  input wire sysclk_sel_secure,
  input wire [23:0] io_secure,
  // asynchronous inputs, synchronised inside
  input wire [23:0] wakeup_pin,
  input wire independent_watchdog_reset,
  input wire independent_watchdog_irq,
  input wire general_dma_event,
  input wire lowpower_dma_event,
  input wire multifunction_filter_event,
  input wire audio_filter_event,
  input wire serial_event,
  input wire main_supply_present,
  input wire reset_src_internal,
  input wire security_enable_option,
  input wire [7:0] fast_internal_osc_req,
  input wire [7:0] multispeed_system_osc_req,
  input wire [7:0] multispeed_kernel_osc_req,
  // control outputs
  output reg [2:0] power_state,
  output reg sysclk_run,
  output reg fast_internal_osc_en,
  output reg multispeed_system_osc_en,
  output reg multispeed_kernel_osc_en,
  output reg [23:0] io_analog,
  output reg [23:0] io_pull_up_en,
  output reg [23:0] io_pull_dn_en,
  output reg reset_pin_pullup_en,
  output reg on_battery,
  output reg battery_charge_en,
  output reg [7:0] tamper_sense_en,
  output reg secure_mode,
  output reg [1:0] voltage_scaling_select,
  output reg [7:0] vmon_ctrl,
  output reg [3:0] general_dma_bank_grant,
  output reg lowpower_dma_bank_grant,
  output reg general_dma_run,
  output reg lowpower_dma_run,
  output reg multifunction_filter_run,
  output reg audio_filter_run,
  output reg serial_run,
  output reg interconnect_run,
  output reg [2:0] second_memory_bank_retain,
  output reg flash_power_down
);

  // ************************************************************
  // mode decode helpers
  // ************************************************************
  // stop 0 to stop 2, where autonomous peripherals keep running (the multi-function filter only up to stop 1)
  function is_stop012;
    input [2:0] st;
    begin
      is_stop012 = (st == `ST_STOP0) || (st == `ST_STOP1) || (st == `ST_STOP2);
    end
  endfunction

  // any low-power state that software can enter
  function is_low_power;
    input [2:0] st;
    begin
      is_low_power = (st != `ST_RUN) && (st != `ST_BATTERY);
    end
  endfunction

  // which wake sources a given state admits
  function [7:0] allowed_src;
    input [2:0] st;
    reg [7:0] a;
    begin
      a = 8'h00;
      if (is_low_power(st)) begin
        a[`SRC_PIN] = 1'b1;
        a[`SRC_WDG_RST] = (st != `ST_SHUTDOWN);
      end
      if (is_stop012(st)) begin
        a[`SRC_WDG_INT] = 1'b1;
        a[`SRC_GDMA] = 1'b1;
        a[`SRC_LPDMA] = 1'b1;
        a[`SRC_ADF] = 1'b1;
        a[`SRC_SERIAL] = 1'b1;
        a[`SRC_MDF] = (st != `ST_STOP2);
      end
      allowed_src = a;
    end
  endfunction

  // ************************************************************
  // input synchronisers
  // ************************************************************
  reg [57:0] sync1_r;
  reg [57:0] sync2_r;
  wire [57:0] async_in;
  assign async_in = {multispeed_kernel_osc_req, multispeed_system_osc_req, fast_internal_osc_req,
                     security_enable_option, reset_src_internal, main_supply_present, serial_event,
                     audio_filter_event, multifunction_filter_event, lowpower_dma_event,
                     general_dma_event, independent_watchdog_irq, independent_watchdog_reset, wakeup_pin};

  // two flops; only the second stage is read by logic; supply resets present, no false battery entry
  always @(posedge clk) begin
    if (srst) begin
      sync1_r <= `SYNC_RESET;
      sync2_r <= `SYNC_RESET;
    end else if (clk_en) begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  wire [23:0] pin_s = sync2_r[23:0];
  wire wdg_rst_s = sync2_r[24];
  wire wdg_irq_s = sync2_r[25];
  wire gdma_s = sync2_r[26];
  wire lpdma_s = sync2_r[27];
  wire mdf_s = sync2_r[28];
  wire adf_s = sync2_r[29];
  wire serial_s = sync2_r[30];
  wire supply_s = sync2_r[31];
  wire rst_int_s = sync2_r[32];
  wire sec_opt_s = sync2_r[33];
  wire [7:0] hsi_req_s = sync2_r[41:34];
  wire [7:0] msys_req_s = sync2_r[49:42];
  wire [7:0] mker_req_s = sync2_r[57:50];

  // ************************************************************
  // software registers
  // ************************************************************
  reg [8:0] mode_ctrl_r;
  reg [23:0] wake_pin_en_r;
  reg [7:0] vmon_r;
  reg [8:0] bat_r;
  reg [1:0] vos_r;
  reg [23:0] pull_up_r;
  reg [23:0] pull_dn_r;
  reg [7:0] wake_src_en_r;
  reg [7:0] wake_flags_r;
  reg [2:0] state_r;
  reg enter_pulse_r;

  // access qualifiers: writes taken when waitrequest is low, read data loaded while it is high
  wire acc_wr = avs_write && !avs_waitrequest;
  wire rd_load = avs_read && avs_waitrequest;
  wire ns_block = secure_mode && !avs_secure;
  wire vos_block = sysclk_sel_secure && !avs_secure;
  wire [23:0] io_wr_mask = avs_secure ? 24'hffffff : ~io_secure;

  // byte-enable expanded write mask
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wd = avs_writedata & be_mask;

  // wake cause detection
  wire [7:0] src_raw = {serial_s, adf_s, mdf_s, lpdma_s, gdma_s, wdg_irq_s, wdg_rst_s,
                        |(pin_s & wake_pin_en_r)};
  wire [7:0] wake_hit = src_raw & wake_src_en_r & allowed_src(state_r);
  wire wake_now = |wake_hit;

  // waitrequest: one wait cycle, then a one-cycle acceptance
  always @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      if (avs_waitrequest && (avs_read || avs_write))
        avs_waitrequest <= 1'b0;
      else
        avs_waitrequest <= 1'b1;
    end
  end

  // register writes and hardware updates
  always @(posedge clk) begin
    if (srst) begin
      mode_ctrl_r <= `MC_RESET;
      wake_pin_en_r <= 24'h0;
      vmon_r <= 8'h00;
      bat_r <= 9'h0ff; // all tamper inputs enabled
      vos_r <= 2'h0;
      pull_up_r <= 24'h0;
      pull_dn_r <= 24'h0;
      wake_src_en_r <= 8'h00;
      wake_flags_r <= 8'h00;
      enter_pulse_r <= 1'b0;
    end else if (clk_en) begin
      enter_pulse_r <= 1'b0;
      if (acc_wr) begin
        case (avs_address)
          `OFF_MODE_CTRL: begin
            if (!ns_block) begin
              mode_ctrl_r <= wd[8:0] & `MC_WR_MASK;
              enter_pulse_r <= wd[`MC_ENTER_BIT];
            end
          end
          `OFF_WAKE_PIN_EN: if (!ns_block) wake_pin_en_r <= wd[23:0];
          `OFF_VMON_CTRL: if (!ns_block) vmon_r <= wd[7:0];
          `OFF_BAT_CTRL: if (!ns_block) bat_r <= wd[8:0];
          `OFF_VOS_CTRL: if (!vos_block) vos_r <= wd[1:0];
          `OFF_PULL_UP: pull_up_r <= (pull_up_r & ~io_wr_mask) | (wd[23:0] & io_wr_mask);
          `OFF_PULL_DN: pull_dn_r <= (pull_dn_r & ~io_wr_mask) | (wd[23:0] & io_wr_mask);
          `OFF_WAKE_SRC_EN: if (!ns_block) wake_src_en_r <= wd[7:0];
          default: ;
        endcase
      end
      // discard pull settings when a wake event ends shutdown
      if ((state_r == `ST_SHUTDOWN) && wake_now) begin
        pull_up_r <= 24'h0;
        pull_dn_r <= 24'h0;
      end
      // sticky wake causes: write one clears, a new cause wins
      if (acc_wr && (avs_address == `OFF_WAKE_FLAGS))
        wake_flags_r <= (wake_flags_r & ~wd[7:0]) | wake_hit;
      else
        wake_flags_r <= wake_flags_r | wake_hit;
    end
  end

  // read mux, loaded as waitrequest drops so data stand at acceptance; protected reads give zero
  always @(posedge clk) begin
    if (srst) begin
      avs_readdata <= `ZERO32;
    end else if (clk_en) begin
      if (rd_load) begin
        case (avs_address)
          `OFF_MODE_CTRL: avs_readdata <= ns_block ? `ZERO32 : {23'h0, mode_ctrl_r};
          `OFF_WAKE_PIN_EN: avs_readdata <= ns_block ? `ZERO32 : {8'h0, wake_pin_en_r};
          `OFF_VMON_CTRL: avs_readdata <= ns_block ? `ZERO32 : {24'h0, vmon_r};
          `OFF_BAT_CTRL: avs_readdata <= ns_block ? `ZERO32 : {23'h0, bat_r};
          `OFF_VOS_CTRL: avs_readdata <= vos_block ? `ZERO32 : {30'h0, vos_r};
          `OFF_PULL_UP: avs_readdata <= {8'h0, pull_up_r & io_wr_mask};
          `OFF_PULL_DN: avs_readdata <= {8'h0, pull_dn_r & io_wr_mask};
          `OFF_WAKE_SRC_EN: avs_readdata <= ns_block ? `ZERO32 : {24'h0, wake_src_en_r};
          `OFF_STATUS: avs_readdata <= {20'h0, multispeed_kernel_osc_en, multispeed_system_osc_en,
                                        fast_internal_osc_en, secure_mode, on_battery, sysclk_run,
                                        1'b0, 2'h0, state_r};
          `OFF_WAKE_FLAGS: avs_readdata <= {24'h0, wake_flags_r};
          default: avs_readdata <= `ZERO32;
        endcase
      end else begin
        avs_readdata <= `ZERO32;
      end
    end
  end

  // ************************************************************
  // power state machine
  // ************************************************************
  reg [2:0] state_nxt;
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `ST_RUN: begin
        if (!supply_s)
          state_nxt = `ST_BATTERY;
        else if (enter_pulse_r && (mode_ctrl_r[2:0] <= `ST_SHUTDOWN))
          state_nxt = mode_ctrl_r[2:0];
      end
      `ST_BATTERY: begin
        // only the return of main supply leaves battery operation
        if (supply_s)
          state_nxt = `ST_RUN;
      end
      `ST_STOP0, `ST_STOP1, `ST_STOP2, `ST_STOP3, `ST_STANDBY, `ST_SHUTDOWN: begin
        if (!supply_s)
          state_nxt = `ST_BATTERY;
        else if (wake_now)
          state_nxt = `ST_RUN;
      end
      default: state_nxt = `ST_RUN;
    endcase
  end

  always @(posedge clk) begin
    if (srst)
      state_r <= `ST_RUN;
    else if (clk_en)
      state_r <= state_nxt;
  end

  // ************************************************************
  // registered control outputs
  // ************************************************************
  always @(posedge clk) begin
    if (srst) begin
      power_state <= `ST_RUN;
      sysclk_run <= 1'b1;
      fast_internal_osc_en <= 1'b0;
      multispeed_system_osc_en <= 1'b0;
      multispeed_kernel_osc_en <= 1'b0;
      io_analog <= 24'hffffff;
      io_pull_up_en <= 24'h0;
      io_pull_dn_en <= 24'h0;
      reset_pin_pullup_en <= 1'b0;
      on_battery <= 1'b0;
      battery_charge_en <= 1'b0;
      tamper_sense_en <= 8'h00;
      secure_mode <= 1'b0;
      voltage_scaling_select <= 2'h0;
      vmon_ctrl <= 8'h00;
      general_dma_bank_grant <= 4'h0;
      lowpower_dma_bank_grant <= 1'b0;
      general_dma_run <= 1'b0;
      lowpower_dma_run <= 1'b0;
      multifunction_filter_run <= 1'b0;
      audio_filter_run <= 1'b0;
      serial_run <= 1'b0;
      interconnect_run <= 1'b0;
      second_memory_bank_retain <= `SEG_FULL;
      flash_power_down <= 1'b0;
    end else if (clk_en) begin
      power_state <= state_nxt;
      sysclk_run <= (state_nxt == `ST_RUN);
      // requested oscillators run only while some peripheral asks
      fast_internal_osc_en <= |hsi_req_s;
      multispeed_system_osc_en <= |msys_req_s;
      multispeed_kernel_osc_en <= |mker_req_s;
      // I/Os stay analog until software releases them
      io_analog <= mode_ctrl_r[`MC_IO_RELEASE_BIT] ? 24'h0 : 24'hffffff;
      if ((state_nxt == `ST_STOP3) || (state_nxt == `ST_STANDBY) || (state_nxt == `ST_SHUTDOWN)) begin
        io_pull_up_en <= pull_up_r;
        io_pull_dn_en <= pull_dn_r;
      end else begin
        io_pull_up_en <= 24'h0;
        io_pull_dn_en <= 24'h0;
      end
      reset_pin_pullup_en <= !rst_int_s;
      on_battery <= (state_nxt == `ST_BATTERY);
      battery_charge_en <= bat_r[`BAT_CHARGE_BIT] && supply_s;
      tamper_sense_en <= bat_r[7:0];
      secure_mode <= sec_opt_s;
      voltage_scaling_select <= vos_r;
      vmon_ctrl <= vmon_r;
      general_dma_bank_grant <= ((state_nxt == `ST_RUN) || (state_nxt == `ST_STOP0) ||
                                 (state_nxt == `ST_STOP1)) ? 4'hf : 4'h0;
      lowpower_dma_bank_grant <= (state_nxt == `ST_RUN) || is_stop012(state_nxt);
      general_dma_run <= (state_nxt == `ST_RUN) || is_stop012(state_nxt);
      lowpower_dma_run <= (state_nxt == `ST_RUN) || is_stop012(state_nxt);
      multifunction_filter_run <= (state_nxt == `ST_RUN) || (state_nxt == `ST_STOP0) ||
                                  (state_nxt == `ST_STOP1);
      audio_filter_run <= (state_nxt == `ST_RUN) || is_stop012(state_nxt);
      serial_run <= (state_nxt == `ST_RUN) || is_stop012(state_nxt);
      interconnect_run <= (state_nxt == `ST_RUN) || is_stop012(state_nxt);
      // retention segments of the second bank while in low power
      if (is_low_power(state_nxt)) begin
        case (mode_ctrl_r[`MC_RET_MSB:`MC_RET_LSB])
          `RET_8K: second_memory_bank_retain <= `SEG_8K;
          `RET_56K: second_memory_bank_retain <= `SEG_56K;
          default: second_memory_bank_retain <= `SEG_FULL;
        endcase
        flash_power_down <= mode_ctrl_r[`MC_FLASH_PD_BIT];
      end else begin
        second_memory_bank_retain <= `SEG_FULL;
        flash_power_down <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// file: low_power_wake_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "low_power_defines.vh"

// ********
// checker on the power controller ports
// ********
module low_power_wake_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_secure,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic secure_mode,
  input wire logic reset_src_internal,
  input wire logic reset_pin_pullup_en,
  input wire logic main_supply_present,
  input wire logic on_battery,
  input wire logic [23:0] io_analog,
  input wire logic [2:0] power_state,
  input wire logic sysclk_run,
  input wire logic [7:0] fast_internal_osc_req,
  input wire logic fast_internal_osc_en,
  input wire logic [3:0] general_dma_bank_grant,
  input wire logic lowpower_dma_bank_grant,
  input wire logic multifunction_filter_run,
  input wire logic flash_power_down
);
  // one clock domain; a frozen clock enable holds all state
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !clk_en);

  AST_RESET_ANALOG: assert property (disable iff (1'b0) srst |=> io_analog == 24'hffffff)
    else $error("i/o not analog under reset");
  AST_PULLUP_INTERNAL: assert property (reset_src_internal [*6] |-> !reset_pin_pullup_en)
    else $error("reset pin pull-up on for internal reset");
  AST_BATTERY_ENTER: assert property ((!main_supply_present) [*6] |-> on_battery)
    else $error("no battery mode without supply");
  AST_BATTERY_HOLD: assert property ((!main_supply_present) [*4] ##0 on_battery |=> on_battery)
    else $error("battery mode left without supply");
  AST_RUN_CLOCK: assert property (power_state == `ST_RUN |-> sysclk_run)
    else $error("run state without system clock");
  AST_OSC_ON: assert property ((fast_internal_osc_req != 8'h00) [*5] |-> fast_internal_osc_en)
    else $error("requested oscillator not started");
  AST_OSC_OFF: assert property ((fast_internal_osc_req == 8'h00) [*5] |-> !fast_internal_osc_en)
    else $error("unrequested oscillator left on");
  AST_GDMA_STOP2: assert property (power_state == `ST_STOP2 && $past(power_state) == `ST_STOP2
    |-> general_dma_bank_grant == 4'h0) else $error("general dma banks granted in stop 2");
  AST_LPDMA_STOP3: assert property ($stable(power_state) && power_state == `ST_STOP3
    |-> !lowpower_dma_bank_grant) else $error("low-power dma bank granted in stop 3");
  AST_MDF_STOP2: assert property ($stable(power_state) && power_state == `ST_STOP2
    |-> !multifunction_filter_run) else $error("multi-function filter runs in stop 2");
  AST_SECURE_READ: assert property (!avs_waitrequest && avs_read && !avs_secure && secure_mode
    && avs_address == `OFF_WAKE_PIN_EN |-> avs_readdata == `ZERO32) else $error("secure data leaked");
  AST_FLASH_DEFAULT: assert property ($fell(srst) |-> !flash_power_down)
    else $error("flash powered down by default");
endmodule

bind low_power_mode_wake_control low_power_wake_props props_i (.*);

`default_nettype wire

// file: periph_wake_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// autonomous peripherals, dma engines and wake pins
// ********
module periph_wake_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic [7:0] src,
  input wire logic [23:0] pins,
  input wire logic [3:0] delay,
  output logic [23:0] wakeup_pin,
  output logic [6:0] ev
);
  logic [3:0] cnt_r = 4'h0;
  logic [3:0] hold_r = 4'h0;
  logic [7:0] src_r = 8'h00;
  logic [23:0] pins_r = 24'h000000;

  // wait the asked delay, then hold the event four cycles
  always @(posedge clk) begin
    if (fire) begin
      cnt_r <= delay + 4'h1;
      src_r <= src;
      pins_r <= pins;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h1) begin
        hold_r <= 4'h4;
      end
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
    end
  end

  // idle lines sit inactive low
  assign wakeup_pin = (hold_r != 4'h0 && src_r[0]) ? pins_r : 24'h000000;
  assign ev = (hold_r != 4'h0) ? src_r[7:1] : 7'h00;
endmodule

`default_nettype wire

// file: test_low_power_mode_wake_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "low_power_defines.vh"

module test_low_power_mode_wake_control;
  logic clk, srst, clk_en, avs_read, avs_write, avs_secure, sysclk_sel_secure, fire;
  logic main_supply_present, reset_src_internal, security_enable_option;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, rd, v, lfsr_r;
  logic [3:0] avs_byteenable, fire_dly;
  logic [23:0] io_secure, pin_val;
  logic [7:0] fast_internal_osc_req, multispeed_system_osc_req, multispeed_kernel_osc_req, fire_src;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, sysclk_run, fast_internal_osc_en, multispeed_system_osc_en, multispeed_kernel_osc_en;
  wire [2:0] power_state, second_memory_bank_retain;
  wire [23:0] wakeup_pin, io_analog, io_pull_up_en, io_pull_dn_en;
  wire reset_pin_pullup_en, on_battery, battery_charge_en, secure_mode, lowpower_dma_bank_grant;
  wire [7:0] tamper_sense_en, vmon_ctrl;
  wire [1:0] voltage_scaling_select;
  wire [3:0] general_dma_bank_grant;
  wire general_dma_run, lowpower_dma_run, multifunction_filter_run, audio_filter_run, serial_run;
  wire interconnect_run, flash_power_down;
  wire [6:0] ev;
  wire independent_watchdog_reset = ev[0];
  wire independent_watchdog_irq = ev[1];
  wire general_dma_event = ev[2];
  wire lowpower_dma_event = ev[3];
  wire multifunction_filter_event = ev[4];
  wire audio_filter_event = ev[5];
  wire serial_event = ev[6];
  int failures, tests_run, m, s, e, i;
  logic [2:0] seg [3] = '{`SEG_8K, `SEG_56K, `SEG_FULL};
  logic [5:0] sec_a [5] = '{`OFF_MODE_CTRL, `OFF_WAKE_PIN_EN, `OFF_VMON_CTRL, `OFF_BAT_CTRL, `OFF_VOS_CTRL};

  low_power_mode_wake_control dut (.*);
  periph_wake_model peer (.clk(clk), .fire(fire), .src(fire_src), .pins(pin_val), .delay(fire_dly),
    .wakeup_pin(wakeup_pin), .ev(ev));

  // ********
  // helpers
  // ********
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // wake permission per mode and source: 1 yes, 0 no, 2 left open
  function automatic int exp_wake(input int md, input int sr);
    case (sr)
      `SRC_PIN: return 1;
      `SRC_WDG_RST: return md <= 4;
      `SRC_WDG_INT, `SRC_ADF: return md <= 2;
      `SRC_MDF: return md <= 1;
      default: return (md == 2) ? 2 : (md <= 1);
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one bus access; hold until waitrequest is seen low, read data taken at the acceptance edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    cyc(1);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      cyc(1);
      n++;
    end
    if (n == 50) begin
      failures++;
      report_and_stop;
    end
    @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // ask the peer for events after a random delay
  task automatic kick(input logic [7:0] sm);
    @(posedge clk);
    lfsr_r = lfsr_next(lfsr_r);
    fire <= 1'b1;
    fire_src <= sm;
    fire_dly <= {2'b00, lfsr_r[1:0]};
    pin_val <= lfsr_r[31:8] | 24'h000001;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ********
  // clock, watchdog, main sequence
  // ********
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #200000;
    failures++;
    report_and_stop;
  end

  initial begin
    {srst, clk_en, avs_secure, main_supply_present} = 4'hf;
    {avs_read, avs_write, sysclk_sel_secure, fire, reset_src_internal, security_enable_option} = 6'h00;
    {avs_address, avs_writedata, io_secure, pin_val, fire_src, fire_dly} = 0;
    {fast_internal_osc_req, multispeed_system_osc_req, multispeed_kernel_osc_req} = 24'h000000;
    avs_byteenable = 4'hf;
    failures = 0;
    tests_run = 0;
    lfsr_r = 32'h22d31385;
    cyc(4);
    chk(io_analog, 24'hffffff);
    chk(flash_power_down, 0);
    srst <= 1'b0;
    cyc(5);
    chk(reset_pin_pullup_en, 1);
    reset_src_internal <= 1'b1;
    cyc(6);
    chk(reset_pin_pullup_en, 0);
    bus(1'b0, 6'h3c, 0);
    chk(rd, 0);
    lfsr_r = lfsr_next(lfsr_r);
    bus(1'b1, `OFF_VMON_CTRL, lfsr_r);
    cyc(2);
    chk(vmon_ctrl, lfsr_r[7:0]);
    repeat (4) begin
      lfsr_r = lfsr_next(lfsr_r);
      fast_internal_osc_req <= lfsr_r[7:0];
      multispeed_system_osc_req <= lfsr_r[15:8] & {8{lfsr_r[16]}};
      multispeed_kernel_osc_req <= lfsr_r[31:24] & {8{lfsr_r[17]}};
      cyc(6);
      chk({fast_internal_osc_en, multispeed_system_osc_en, multispeed_kernel_osc_en}, {|fast_internal_osc_req,
        |multispeed_system_osc_req, |multispeed_kernel_osc_req});
    end
    {fast_internal_osc_req, multispeed_system_osc_req, multispeed_kernel_osc_req} <= 24'h000000;
    cyc(6);
    chk({fast_internal_osc_en, multispeed_system_osc_en, multispeed_kernel_osc_en}, 0);
    // every low-power mode against every wake source
    bus(1'b1, `OFF_WAKE_PIN_EN, 32'h00ffffff);
    bus(1'b1, `OFF_PULL_UP, 32'h00a5a5a5);
    for (m = 0; m < 6; m++) begin
      for (s = 0; s < 8; s++) begin
        bus(1'b1, `OFF_WAKE_FLAGS, 32'hff);
        bus(1'b1, `OFF_WAKE_SRC_EN, (1 << s) | 1);
        bus(1'b1, `OFF_MODE_CTRL, ((m % 3) << 5) | ((m & 1) << 7) | 16 | m);
        cyc(4);
        chk(power_state, m);
        chk({general_dma_bank_grant, lowpower_dma_bank_grant, general_dma_run, lowpower_dma_run,
          multifunction_filter_run, audio_filter_run, serial_run, interconnect_run}, {{4{m <= 1}}, m <= 2,
          m <= 2, m <= 2, m <= 1, m <= 2, m <= 2, m <= 2});
        if (m < 4) chk(second_memory_bank_retain, seg[m % 3]);
        if (m < 4) chk(flash_power_down, m & 1);
        if (m == 5 && s == 0) chk(io_pull_up_en, 24'ha5a5a5);
        kick(8'h01 << s);
        cyc(14);
        e = exp_wake(m, s);
        if (e != 2) chk(power_state, e ? `ST_RUN : m);
        if (power_state !== `ST_RUN) kick(8'h01);
        cyc(14);
        chk(power_state, `ST_RUN);
        if (m == 5) chk(io_pull_up_en, 0);
        if (m == 5) bus(1'b0, `OFF_PULL_UP, 0);
        if (m == 5) chk(rd, 0);
      end
    end
    // security option on: protected fields hide from non-secure masters
    security_enable_option <= 1'b1;
    sysclk_sel_secure <= 1'b1;
    io_secure <= 24'h0000ff;
    cyc(6);
    chk(secure_mode, 1);
    for (i = 0; i < 5; i++) begin
      avs_secure <= 1'b1;
      bus(1'b0, sec_a[i], 0);
      v = rd;
      avs_secure <= 1'b0;
      bus(1'b1, sec_a[i], ~v);
      bus(1'b0, sec_a[i], 0);
      chk(rd, 0);
      avs_secure <= 1'b1;
      bus(1'b0, sec_a[i], 0);
      chk(rd, v);
    end
    bus(1'b1, `OFF_PULL_UP, 32'h00ffffff);
    avs_secure <= 1'b0;
    bus(1'b1, `OFF_PULL_UP, 32'h00ff0000);
    chk(rd, 0); // write carries no read data
    bus(1'b0, `OFF_PULL_UP, 0);
    chk(rd, 32'h00ff0000);
    avs_secure <= 1'b1;
    bus(1'b0, `OFF_PULL_UP, 0);
    chk(rd, 32'h00ff00ff);
    // supply loss: battery mode holds against every event
    bus(1'b1, `OFF_WAKE_SRC_EN, 32'hff);
    main_supply_present <= 1'b0;
    cyc(8);
    chk(power_state, `ST_BATTERY);
    chk(tamper_sense_en, 8'hff);
    kick(8'hff);
    cyc(14);
    chk(on_battery, 1);
    main_supply_present <= 1'b1;
    cyc(8);
    chk(power_state, `ST_RUN);
    report_and_stop;
  end
endmodule

`default_nettype wire
